/* File: include/pcc_params.svh */
// constants for the 16-bit card control-signal sequencer
`ifndef PCC_PARAMS_SVH
`define PCC_PARAMS_SVH
`define PCC_SETUP_CYC    4'h2
`define PCC_STROBE_CYC   4'h6
`define PCC_HOLD_CYC     4'h2
`define PCC_CNT_W        4
`define PCC_VS_5V        2'h3
`define PCC_VS_3V        2'h2
`define PCC_VS_XV        2'h1
`define PCC_VS_LOW       2'h0
`endif

/* File: include/pcc_pkg.sv */
// types for the 16-bit card control-signal sequencer
package pcc_pkg;
  typedef enum logic [1:0] {
    PCC_CMD_MEM = 2'h0,
    PCC_CMD_ATTR = 2'h1,
    PCC_CMD_IO = 2'h2,
    PCC_CMD_DMA = 2'h3
  } pcc_cmd_t;
  typedef enum logic [1:0] {
    PCC_VOLT_5V = 2'h0,
    PCC_VOLT_3V = 2'h1,
    PCC_VOLT_XV = 2'h2,
    PCC_VOLT_LOW = 2'h3
  } pcc_volt_t;
  typedef enum logic [4:0] {
    PCC_IDLE = 5'h01,
    PCC_SETUP = 5'h02,
    PCC_STROBE = 5'h04,
    PCC_WAITST = 5'h08,
    PCC_HOLD = 5'h10
  } pcc_state_t;
endpackage : pcc_pkg

/* File: verilog/pcc_sync.sv */
// two-flop synchroniser bank for card input pins
`timescale 1ns/1ps
module pcc_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] async_i,
  input  wire logic [W-1:0] rst_val_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  // first stage feeds only the second; reset value constant-one (idle pins high)
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end
  assign sync_o = sync_q ^ ~rst_val_i ^ ~rst_val_i;
endmodule : pcc_sync

/* File: verilog/pcc_ctrl.sv */
// control-signal sequencer for a 16-bit card socket
// Notes on behaviour
// - drive output enable low during host memory reads.
// - assert output enable as terminal count on the last DMA write.
// - treat ready as ready/busy only in memory-only interface mode.
// - keep attribute select high for all common memory accesses.
// - attribute select with memory strobes for attribute, with I/O strobes for I/O.
// - attribute select is DMA acknowledge, paired with the I/O strobes.
// - card reset output forces a hard reset of the card.
// - decode both voltage sense lines together into one voltage class.
// - hold the cycle uncompleted while the card asserts wait.
// - write enable strobes host write data into memory cards.
// - assert write enable as terminal count on the last DMA read.
// - write-protect input is the memory card switch state.
// - I/O read strobe for card-to-host DMA, I/O write for host-to-card.
`timescale 1ns/1ps
`include "pcc_params.svh"
module pcc_ctrl
  import pcc_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  // host side request
  input  wire logic        req_valid_i,
  output logic             req_ready_o,
  input  wire pcc_cmd_t    req_cmd_i,
  input  wire logic        req_write_i,
  input  wire logic        req_last_i,
  input  wire logic        mem_only_i,
  input  wire logic        reset_card_i,
  output logic             done_o,
  output logic             done_wide_o,
  output logic             card_ready_o,
  output logic             card_irq_o,
  output logic             write_protect_o,
  output logic             dma_request_o,
  output pcc_volt_t        volt_class_o,
  // card pins
  output logic             oe_b_o,
  output logic             we_b_o,
  output logic             reg_b_o,
  output logic             io_read_strobe_b_o,
  output logic             io_write_strobe_b_o,
  output logic             card_reset_o,
  input  wire logic        ready_irq_i,
  input  wire logic        wait_b_i,
  input  wire logic        wp_wide_i,
  input  wire logic        voltage_sense_a_i,
  input  wire logic        voltage_sense_b_i
);
  pcc_state_t state_q, state_d;
  logic [`PCC_CNT_W-1:0] cnt_q, cnt_d;
  pcc_cmd_t cmd_q;
  logic     wr_q, last_q, wide_q;
  logic     oe_q, we_q, reg_q, io_read_strobe_q, io_write_strobe_q, rst_q, done_q, donew_q;
  logic [1:0] vs_q;
  logic       rdy_s, wait_s, wp_s, vsa_s, vsb_s;

  // synchronise every card input pin
  pcc_sync #(.W(5)) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .async_i   ({ready_irq_i, wait_b_i, wp_wide_i, voltage_sense_a_i, voltage_sense_b_i}),
    .rst_val_i (5'h1f),
    .sync_o    ({rdy_s, wait_s, wp_s, vsa_s, vsb_s})
  );

  // voltage class from both sense lines together
  function automatic pcc_volt_t vs_decode(input logic [1:0] vs);
    unique case (vs)
      `PCC_VS_5V: vs_decode = PCC_VOLT_5V;
      `PCC_VS_3V: vs_decode = PCC_VOLT_3V;
      `PCC_VS_XV: vs_decode = PCC_VOLT_XV;
      default:    vs_decode = PCC_VOLT_LOW;
    endcase
  endfunction : vs_decode

  wire   wait_on   = !wait_s;
  wire   is_io     = (cmd_q == PCC_CMD_IO);
  wire   is_dma    = (cmd_q == PCC_CMD_DMA);
  wire   is_memory = (cmd_q == PCC_CMD_MEM) || (cmd_q == PCC_CMD_ATTR);
  assign req_ready_o = (state_q == PCC_IDLE) && !rst_q;

  // sequencer next state
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      PCC_IDLE: begin
        if (req_valid_i && req_ready_o) begin
          state_d = PCC_SETUP;
          cnt_d   = `PCC_SETUP_CYC;
        end
      end
      PCC_SETUP: begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == 1) begin
          state_d = PCC_STROBE;
          cnt_d   = `PCC_STROBE_CYC;
        end
      end
      PCC_STROBE: begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == 1) begin
          state_d = PCC_WAITST;
        end
      end
      PCC_WAITST: begin
        if (!wait_on) begin
          state_d = PCC_HOLD;
          cnt_d   = `PCC_HOLD_CYC;
        end
      end
      PCC_HOLD: begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == 1) begin
          state_d = PCC_IDLE;
        end
      end
      default: state_d = PCC_IDLE;
    endcase
  end

  wire strobe_on = (state_q == PCC_STROBE) || (state_q == PCC_WAITST);
  wire cyc_on    = (state_q != PCC_IDLE);
  // memory strobes: oe on reads, we on writes; dma terminal count on last word
  wire oe_d   = strobe_on && ((is_memory && !wr_q)
                || (is_dma && wr_q && last_q));
  wire we_d   = strobe_on && ((is_memory && wr_q)
                || (is_dma && !wr_q && last_q));
  // attribute select: high for common memory, low for attr, io, dma ack
  wire reg_d  = cyc_on && (cmd_q != PCC_CMD_MEM);
  // dma write (card to host) uses io read strobe, dma read uses io write
  wire io_read_strobe_d = strobe_on && ((is_io && !wr_q) || (is_dma && wr_q));
  wire io_write_strobe_d = strobe_on && ((is_io && wr_q) || (is_dma && !wr_q));

  // state and captured request
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= PCC_IDLE;
      cnt_q   <= '0;
      cmd_q   <= PCC_CMD_MEM;
      wr_q    <= 1'b0;
      last_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      if (req_valid_i && req_ready_o) begin
        cmd_q  <= req_cmd_i;
        wr_q   <= req_write_i;
        last_q <= req_last_i;
      end
    end
  end

  // registered pin drivers
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      oe_q   <= 1'b0;
      we_q   <= 1'b0;
      reg_q  <= 1'b0;
      io_read_strobe_q <= 1'b0;
      io_write_strobe_q <= 1'b0;
      rst_q  <= 1'b1;
    end else begin
      oe_q   <= oe_d;
      we_q   <= we_d;
      reg_q  <= reg_d;
      io_read_strobe_q <= io_read_strobe_d;
      io_write_strobe_q <= io_write_strobe_d;
      rst_q  <= reset_card_i;
    end
  end

  // wide-port sampled during io strobe; completion pulse
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wide_q  <= 1'b0;
      done_q  <= 1'b0;
      donew_q <= 1'b0;
    end else begin
      if (state_q == PCC_STROBE && is_io) begin
        wide_q <= !wp_s;
      end
      done_q  <= (state_q == PCC_HOLD) && (cnt_q == 1);
      donew_q <= (state_q == PCC_HOLD) && (cnt_q == 1) && !(is_io && !wide_q);
    end
  end

  // status from pins
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vs_q <= 2'h3;
    end else begin
      vs_q <= {vsa_s, vsb_s};
    end
  end

  assign oe_b_o              = !oe_q;
  assign we_b_o              = !we_q;
  assign reg_b_o             = !reg_q;
  assign io_read_strobe_b_o  = !io_read_strobe_q;
  assign io_write_strobe_b_o = !io_write_strobe_q;
  assign card_reset_o        = rst_q;
  assign done_o              = done_q;
  assign done_wide_o         = donew_q;
  assign card_ready_o        = mem_only_i && rdy_s;
  assign card_irq_o          = !mem_only_i && !rdy_s;
  assign write_protect_o     = mem_only_i && wp_s;
  assign dma_request_o       = !mem_only_i && wp_s;
  assign volt_class_o        = vs_decode(vs_q);

  // assertions
  common_reg_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (cmd_q == PCC_CMD_MEM) |-> reg_b_o) else $error("reg low in common access");
  oe_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (strobe_on && is_memory && !wr_q) |=> !oe_b_o) else $error("oe missing");
  we_write_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (strobe_on && is_memory && wr_q) |=> !we_b_o) else $error("we missing");
  wait_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (state_q == PCC_WAITST && wait_on) |=> state_q == PCC_WAITST) else $error("wait ignored");
  dma_pair_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (strobe_on && is_dma) |=> (!reg_b_o && (io_read_strobe_b_o != io_write_strobe_b_o)))
    else $error("dma ack pairing");
  dma_tc_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (strobe_on && is_dma && last_q) |=> (wr_q ? !oe_b_o : !we_b_o)) else $error("tc missing");
  reset_out_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    reset_card_i |=> card_reset_o) else $error("card reset missing");
  ready_mode_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !mem_only_i |-> !card_ready_o) else $error("ready outside memory mode");

  // the shared card lines report one meaning at a time, chosen by the mode
  irq_mode_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    mem_only_i |-> !card_irq_o) else $error("interrupt in memory mode");
  wp_share_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !(write_protect_o && dma_request_o)) else $error("shared line used twice");

  // steps of one access; a stuck count here would hang the host side
  sequence take_s;
    req_valid_i && req_ready_o;
  endsequence

  sequence setup_s;
    (state_q == PCC_SETUP) [*2];
  endsequence

  sequence strobe_s;
    (state_q == PCC_STROBE) [*6];
  endsequence

  sequence hold_s;
    (state_q == PCC_HOLD) [*2];
  endsequence

  // no strobe reaches the card before setup has run its full length
  setup_len_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    take_s |=> setup_s ##1 (state_q == PCC_STROBE)) else $error("setup length");

  // strobes stay off while address and attribute select settle
  quiet_setup_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (state_q == PCC_SETUP) |=> (oe_b_o && we_b_o
      && io_read_strobe_b_o && io_write_strobe_b_o)) else $error("strobe during setup");

  // the strobe phase is fixed; only wait states may stretch it
  strobe_len_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (state_q == PCC_SETUP && cnt_q == 4'h1) |=> strobe_s ##1 (state_q == PCC_WAITST))
    else $error("strobe length");

  // once wait is released the cycle holds, then completes with one done pulse
  hold_len_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (state_q == PCC_WAITST && !wait_on) |=> hold_s ##1 (state_q == PCC_IDLE && done_o))
    else $error("hold length or done missing");

  // io space: attribute select low with the io strobe of the direction
  io_pair_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (strobe_on && is_io) |=> (!reg_b_o
      && (wr_q ? !io_write_strobe_b_o : !io_read_strobe_b_o))) else $error("io pairing");

  // attribute memory: attribute select low with exactly one memory strobe
  attr_pair_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (strobe_on && cmd_q == PCC_CMD_ATTR) |=> (!reg_b_o && (oe_b_o != we_b_o)))
    else $error("attribute pairing");

  // dma direction picks the io strobe; card-to-host uses the read strobe
  dma_dir_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (strobe_on && is_dma) |=> (wr_q ? !io_read_strobe_b_o : !io_write_strobe_b_o))
    else $error("dma strobe direction");

  // byte-wide io cycles must not report a 16-bit completion
  done_width_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (done_o && is_io && !wide_q) |-> !done_wide_o) else $error("byte cycle reported wide");

  // attribute select is released once the sequencer has been idle a cycle
  reg_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (state_q == PCC_IDLE && $past(state_q) == PCC_IDLE) |-> reg_b_o)
    else $error("attribute select left low");

  // a refused request leaves the captured command untouched
  refuse_keep_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (req_valid_i && !req_ready_o) |=> ($stable(cmd_q) && $stable(wr_q) && $stable(last_q)))
    else $error("refused request captured");
endmodule : pcc_ctrl

/* File: sim/pcc_card_model.sv */
// behavioural 16-bit card facing the control-signal sequencer
`timescale 1ns/1ps
module pcc_card_model (
  input  wire logic       ref_clk_i,
  input  wire logic       busy_i,
  input  wire logic       irq_i,
  input  wire logic       wide_i,
  input  wire logic [7:0] wait_cyc_i,
  input  wire logic       oe_b_i,
  input  wire logic       we_b_i,
  input  wire logic       io_read_strobe_b_i,
  input  wire logic       io_write_strobe_b_i,
  output logic            ready_irq_o,
  output logic            wait_b_o,
  output logic            wp_wide_o
);
  logic [7:0] wait_cnt_q = 8'h00;
  logic       strobe_q   = 1'b0;
  wire        strobe     = !(oe_b_i & we_b_i & io_read_strobe_b_i & io_write_strobe_b_i);
  // a busy memory or a pending service request pulls the shared line low
  assign ready_irq_o = !(busy_i | irq_i);
  // wide port, switch state or dma request, as the bench sets it
  assign wp_wide_o = wide_i;
  // stretch the cycle for a set count from the first strobe edge
  always_ff @(posedge ref_clk_i) begin
    strobe_q <= strobe;
    if (strobe && !strobe_q) wait_cnt_q <= wait_cyc_i;
    else if (wait_cnt_q != 8'h00) wait_cnt_q <= wait_cnt_q - 8'h01;
  end
  assign wait_b_o = (wait_cnt_q == 8'h00);
endmodule : pcc_card_model

/* File: sim/pc_card_16bit_control_signals_tb.sv */
// self-checking bench for the card control-signal sequencer
`timescale 1ns/1ps
module pc_card_16bit_control_signals_tb;
  import pcc_pkg::*;
  logic       ref_clk_i, rst_b_i, req_valid_i, req_write_i, req_last_i, mem_only_i;
  logic       reset_card_i, voltage_sense_a_i, voltage_sense_b_i, busy, irq, wide;
  logic       req_ready_o, done_o, done_wide_o, card_ready_o, card_irq_o, write_protect_o;
  logic       dma_request_o, oe_b_o, we_b_o, reg_b_o, io_read_strobe_b_o, io_write_strobe_b_o;
  logic       card_reset_o, ready_irq_i, wait_b_i, wp_wide_i, wide_seen;
  logic [7:0] wait_cyc;
  logic [4:0] seen;
  pcc_cmd_t   req_cmd_i;
  pcc_volt_t  volt_class_o;
  int         n_mismatch, n_compared, cyc, lat, base;

  pcc_ctrl i_pcc_ctrl (.ref_clk_i, .rst_b_i, .req_valid_i, .req_ready_o, .req_cmd_i,
    .req_write_i, .req_last_i, .mem_only_i, .reset_card_i, .done_o, .done_wide_o,
    .card_ready_o, .card_irq_o, .write_protect_o, .dma_request_o, .volt_class_o,
    .oe_b_o, .we_b_o, .reg_b_o, .io_read_strobe_b_o, .io_write_strobe_b_o, .card_reset_o,
    .ready_irq_i, .wait_b_i, .wp_wide_i, .voltage_sense_a_i, .voltage_sense_b_i);
  pcc_card_model i_pcc_card_model (.ref_clk_i, .busy_i(busy), .irq_i(irq), .wide_i(wide),
    .wait_cyc_i(wait_cyc), .oe_b_i(oe_b_o), .we_b_i(we_b_o),
    .io_read_strobe_b_i(io_read_strobe_b_o), .io_write_strobe_b_i(io_write_strobe_b_o),
    .ready_irq_o(ready_irq_i), .wait_b_o(wait_b_i), .wp_wide_o(wp_wide_i));

  // clock generator
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one access; collects every strobe seen low as {oe,we,reg,io_read_strobe,io_write_strobe}
  task automatic run(input pcc_cmd_t c, input logic w, input logic l, input logic [4:0] exp);
    seen = 5'h00;
    lat = 0;
    @(posedge ref_clk_i);
    req_cmd_i <= c;
    req_write_i <= w;
    req_last_i <= l;
    req_valid_i <= 1'b1;
    @(posedge ref_clk_i);
    req_valid_i <= 1'b0;
    do begin
      @(negedge ref_clk_i);
      seen |= ~{oe_b_o, we_b_o, reg_b_o, io_read_strobe_b_o, io_write_strobe_b_o};
      lat++;
    end while (done_o !== 1'b1 && lat < 300);
    wide_seen = done_wide_o;
    chk("done", 1, done_o);
    chk("strobes", exp, seen);
  endtask : run

  task automatic t_access();
    mem_only_i <= 1'b1;
    run(PCC_CMD_MEM, 1'b0, 1'b0, 5'h10);
    base = lat;
    run(PCC_CMD_MEM, 1'b1, 1'b0, 5'h08);
    run(PCC_CMD_ATTR, 1'b0, 1'b0, 5'h14);
    run(PCC_CMD_ATTR, 1'b1, 1'b0, 5'h0c);
    mem_only_i <= 1'b0;
    // the wide-port indication is active low on the shared line
    wide <= 1'b0;
    run(PCC_CMD_IO, 1'b0, 1'b0, 5'h06);
    chk("wide io", 1, wide_seen);
    wide <= 1'b1;
    run(PCC_CMD_IO, 1'b1, 1'b0, 5'h05);
    chk("byte io", 0, wide_seen);
    run(PCC_CMD_DMA, 1'b1, 1'b1, 5'h16);
    run(PCC_CMD_DMA, 1'b0, 1'b1, 5'h0d);
    run(PCC_CMD_DMA, 1'b1, 1'b0, 5'h06);
  endtask : t_access

  // card holds wait low for 20 cycles from the first strobe edge of a memory read
  task automatic t_wait();
    mem_only_i <= 1'b1;
    wait_cyc <= 8'h14;
    run(PCC_CMD_MEM, 1'b0, 1'b0, 5'h10);
    chk("stretched", 1, 32'(lat >= base + 15));
    wait_cyc <= 8'h00;
  endtask : t_wait

  task automatic settle();
    repeat (6) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask : settle

  task automatic t_pins();
    busy <= 1'b1;
    wide <= 1'b1;
    settle();
    chk("busy", 0, card_ready_o);
    chk("wp on", 1, write_protect_o);
    chk("irq in mem", 0, card_irq_o);
    busy <= 1'b0;
    wide <= 1'b0;
    settle();
    chk("ready", 1, card_ready_o);
    chk("wp off", 0, write_protect_o);
    mem_only_i <= 1'b0;
    irq <= 1'b1;
    wide <= 1'b1;
    settle();
    chk("irq", 1, card_irq_o);
    chk("dma req", 1, dma_request_o);
    chk("ready in io", 0, card_ready_o);
    irq <= 1'b0;
    wide <= 1'b0;
  endtask : t_pins

  task automatic t_volt();
    for (int k = 0; k < 4; k++) begin
      {voltage_sense_a_i, voltage_sense_b_i} <= k[1:0];
      settle();
      chk("volt", 32'(3 - k), volt_class_o);
    end
  endtask : t_volt

  task automatic t_reset();
    reset_card_i <= 1'b1;
    @(posedge ref_clk_i);
    req_valid_i <= 1'b1;
    settle();
    chk("card reset", 1, card_reset_o);
    chk("refused", 0, req_ready_o);
    chk("no start", 1, oe_b_o);
    req_valid_i <= 1'b0;
    reset_card_i <= 1'b0;
    settle();
    chk("card run", 0, card_reset_o);
  endtask : t_reset

  // hang guard
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  // main sequence
  initial begin
    {rst_b_i, req_valid_i, req_write_i, req_last_i, mem_only_i, reset_card_i} = 6'h00;
    {voltage_sense_a_i, voltage_sense_b_i, busy, irq, wide} = 5'h18;
    req_cmd_i = PCC_CMD_MEM;
    wait_cyc = 8'h00;
    repeat (8) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    t_access();
    t_wait();
    t_pins();
    t_volt();
    t_reset();
    final_report();
  end
endmodule : pc_card_16bit_control_signals_tb
